// >>> hw/scp_core.sv
// Serial port controller: master select handling, mode fault, slave shifting, write protection
`timescale 1ns/10ps
module scp_core
	import scp_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Host commands
	input wire logic enableCommand,
	input wire logic disableCommand,
	input wire logic finalWordRelease,
	input wire logic txWrite,
	input wire logic [15:0] txData,
	input wire logic [3:0] txPcs,
	input wire logic rxRead,
	input wire logic statusRead,
	input wire logic wpStatusRead,
	// Configuration writes
	input wire logic modeWrite,
	input wire scp_mode_t modeData,
	input wire logic csrWrite,
	input wire logic [1:0] csrIndex,
	input wire scp_csr_t csrData,
	input wire logic wpModeWrite,
	input wire logic writeProtectOn,
	// Host view
	output scp_status_t status,
	output logic [15:0] receiveDataReg,
	output scp_wp_status_t wpStatus,
	// Serial pins
	input wire logic serialClockIn,
	output logic serialClockOut,
	output logic serialClockOeN,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOeN,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOeN,
	input wire logic slaveSelectIn,
	output logic [3:0] selectOut,
	output logic selectOeN
);

	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function automatic logic [1:0] csIndexOf(input logic [3:0] pcs);
		csIndexOf = !pcs[0] ? 2'd0 : !pcs[1] ? 2'd1 : !pcs[2] ? 2'd2 : 2'd3;
	endfunction

	function automatic logic topBit(input logic [15:0] w, input logic [4:0] n);
		topBit = w[4'(n - 5'd1)];
	endfunction

	function automatic logic [4:0] lenOf(input scp_csr_t c);
		lenOf = BASE_WORD_LEN + {1'b0, c.extraBits};
	endfunction

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	logic [3:0] pinRaw;
	logic [3:0] syncA_q;
	logic [3:0] syncB_q;
	logic sckPrev_q;
	logic nssPrev_q;
	assign pinRaw = {serialClockIn, mosiIn, misoIn, slaveSelectIn};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge clock or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					syncA_q[gi] <= 1'b1;
					syncB_q[gi] <= 1'b1;
				end
				else
				begin
					syncA_q[gi] <= pinRaw[gi];
					syncB_q[gi] <= syncA_q[gi];
				end
			end
		end
	endgenerate
	wire sckS = syncB_q[3];
	wire mosiS = syncB_q[2];
	wire misoS = syncB_q[1];
	wire nssS = syncB_q[0];

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	scp_mode_t mode_q;
	scp_csr_t csr_q [4];
	logic wpOn_q, wpViol_q, enabled_q;
	logic [7:0] wpSrc_q;
	logic [15:0] tdr_q, sh_q, rxData_q;
	logic [3:0] tdrPcs_q;
	logic tdrLast_q, txFull_q, lastReq_q, hasTx_q, rxFull_q;
	logic modeFault_q, overrun_q, underrun_q, outBit_q, sckLvl_q;
	logic csActive_q, curLast_q;
	logic [1:0] csCur_q;
	logic [7:0] gapCnt_q, divCnt_q;
	logic [5:0] cnt_q;
	scp_mstate_t ms_q;
	logic [1:0] ownLow_q;

	// ---------------------------------------------
	// Decode
	// ---------------------------------------------
	wire isMaster = mode_q.master;
	wire [3:0] targetPcs = mode_q.variableSelect ? tdrPcs_q : mode_q.pcs;
	wire [1:0] targetIdx = csIndexOf(targetPcs);
	scp_csr_t tgtCfg, curCfg;
	assign tgtCfg = csr_q[targetIdx];
	assign curCfg = isMaster ? csr_q[csCur_q] : csr_q[0];
	wire [4:0] curLen = lenOf(curCfg);
	wire [4:0] len0 = lenOf(csr_q[0]);
	wire [7:0] gapLen = (mode_q.interSelectDelay <= MIN_GAP_CYCLES) ? MIN_GAP_CYCLES
		: mode_q.interSelectDelay;
	wire [7:0] divLen = (curCfg.divider == 8'h00) ? 8'h01 : curCfg.divider;
	wire cfgBlocked = (modeWrite || csrWrite) && wpOn_q;

	// Mode fault, ignoring our own drive of the first line and its two-cycle echo through the synchroniser
	wire ownLowNow = isMaster && enabled_q && csActive_q && csCur_q == 2'd0;
	wire faultEv = isMaster && enabled_q && !mode_q.modeFaultDisable && !nssS
		&& !ownLowNow && ownLow_q == 2'b00;

	// Master edges
	wire mTick = (ms_q == MS_SHIFT) && (divCnt_q == divLen - 8'h01);
	wire mLead = !cnt_q[0];
	wire mSample = mTick && (mLead == curCfg.clockPhaseInverted);
	wire mShift = mTick && (mLead != curCfg.clockPhaseInverted) && (cnt_q != 6'd0);
	wire mDone = mTick && (cnt_q == {curLen, 1'b0} - 6'd1);
	wire mSameCs = csActive_q && csCur_q == targetIdx;
	wire mGo = enabled_q && isMaster && txFull_q;
	wire mLoad = (ms_q == MS_IDLE) && mGo && (mSameCs || !csActive_q);
	wire mSwitch = (ms_q == MS_IDLE) && mGo && csActive_q && !mSameCs;
	wire mHold = curCfg.holdSelectAfterWord && !curLast_q;
	wire mForce = !curCfg.holdSelectAfterWord && curCfg.forceReleaseAfterWord;
	wire mKeep = mHold || (!curLast_q && !mForce && txFull_q && mSameCs);
	wire mRelease = mSwitch || (mDone && !mKeep);

	// Slave edges, clock honoured only while selected
	wire sActive = !isMaster && enabled_q && !nssS;
	wire sRise = sckS && !sckPrev_q;
	wire sFall = !sckS && sckPrev_q;
	wire sLead = curCfg.clockPolarity ? sFall : sRise;
	wire sTrail = curCfg.clockPolarity ? sRise : sFall;
	wire sSample = sActive && (curCfg.clockPhaseInverted ? sLead : sTrail);
	wire sShift = sActive && (curCfg.clockPhaseInverted ? sTrail : sLead) && (cnt_q != 6'd0);
	wire sDone = sSample && (cnt_q == {1'b0, len0} - 6'd1);
	wire sNssFall = !isMaster && enabled_q && !nssS && nssPrev_q;
	wire sLoadPend = (sNssFall || sDone) && txFull_q;
	wire sUnder = sDone && !txFull_q && hasTx_q;
	wire sDirect = txWrite && !isMaster && !hasTx_q;

	// Shared shifter
	wire sampleNow = mSample || sSample;
	wire shiftNow = mShift || sShift;
	wire sampleBit = isMaster ? misoS : mosiS;
	wire [15:0] shifted = {sh_q[14:0], sampleBit};
	wire [15:0] rxNext = sampleNow ? shifted : sh_q;
	logic [15:0] rxWord;
	always_comb
	begin
		for (int i = 0; i < 16; i++)
			rxWord[i] = rxNext[i] && (5'(i) < curLen);
	end
	wire wordDone = mDone || sDone;
	wire loadTdr = mLoad || sLoadPend || sUnder;
	wire [4:0] ldLen = isMaster ? lenOf(tgtCfg) : len0;
	wire [15:0] sh_d = loadTdr ? tdr_q : sDirect ? txData : sampleNow ? shifted : sh_q;
	wire outBit_d = loadTdr ? topBit(tdr_q, ldLen)
		: sDirect ? topBit(txData, len0)
		: sDone ? topBit(rxNext, len0)
		: sNssFall ? topBit(sh_q, len0)
		: shiftNow ? topBit(sh_q, curLen) : outBit_q;
	wire [5:0] cnt_d = mLoad ? 6'd0 : mTick ? cnt_q + 6'd1
		: (!isMaster && nssS) ? 6'd0 : sDone ? 6'd0 : sSample ? cnt_q + 6'd1 : cnt_q;

	// ---------------------------------------------
	// Configuration and protection
	// ---------------------------------------------
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode_q <= '0;
			for (int i = 0; i < 4; i++)
				csr_q[i] <= '0;
			wpOn_q <= 1'b0;
			wpViol_q <= 1'b0;
			wpSrc_q <= 8'h00;
		end
		else
		begin
			if (modeWrite && !wpOn_q)
				mode_q <= modeData;
			if (csrWrite && !wpOn_q)
				csr_q[csrIndex] <= csrData;
			if (wpModeWrite)
				wpOn_q <= writeProtectOn;
			if (cfgBlocked)
			begin
				wpViol_q <= 1'b1;
				wpSrc_q <= modeWrite ? MODE_REG_OFFSET : CSR_BASE_OFFSET + {4'h0, csrIndex, 2'b00};
			end
			else if (wpStatusRead)
				wpViol_q <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Transmit holding, flags, shifter
	// ---------------------------------------------
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			enabled_q <= 1'b0;
			tdr_q <= SHIFT_RESET;
			tdrPcs_q <= 4'hF;
			tdrLast_q <= 1'b0;
			txFull_q <= 1'b0;
			lastReq_q <= 1'b0;
			hasTx_q <= 1'b0;
			rxFull_q <= 1'b0;
			rxData_q <= SHIFT_RESET;
			modeFault_q <= 1'b0;
			overrun_q <= 1'b0;
			underrun_q <= 1'b0;
			sh_q <= SHIFT_RESET;
			outBit_q <= 1'b0;
			cnt_q <= 6'd0;
			sckPrev_q <= 1'b1;
			nssPrev_q <= 1'b1;
			ownLow_q <= 2'b00;
		end
		else
		begin
			sckPrev_q <= sckS;
			nssPrev_q <= nssS;
			ownLow_q <= {ownLow_q[0], ownLowNow};
			if (faultEv || disableCommand)
				enabled_q <= 1'b0;
			else if (enableCommand)
				enabled_q <= 1'b1;
			// A write consumes the armed release so it never leaks into the next word
			if (txWrite)
				lastReq_q <= 1'b0;
			else if (finalWordRelease)
				lastReq_q <= 1'b1;
			if (txWrite)
			begin
				tdr_q <= txData;
				tdrPcs_q <= txPcs;
				tdrLast_q <= lastReq_q || finalWordRelease;
				hasTx_q <= 1'b1;
			end
			txFull_q <= (txWrite && !sDirect) ? 1'b1 : loadTdr ? 1'b0 : txFull_q;
			sh_q <= sh_d;
			outBit_q <= outBit_d;
			cnt_q <= cnt_d;
			if (wordDone)
				rxData_q <= rxWord;
			rxFull_q <= wordDone ? 1'b1 : rxRead ? 1'b0 : rxFull_q;
			overrun_q <= (wordDone && rxFull_q && !rxRead) ? 1'b1 : statusRead ? 1'b0 : overrun_q;
			underrun_q <= sUnder ? 1'b1 : statusRead ? 1'b0 : underrun_q;
			modeFault_q <= faultEv ? 1'b1 : statusRead ? 1'b0 : modeFault_q;
		end
	end

	// ---------------------------------------------
	// Master select sequencer
	// ---------------------------------------------
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ms_q <= MS_IDLE;
			csActive_q <= 1'b0;
			csCur_q <= 2'd0;
			curLast_q <= 1'b0;
			gapCnt_q <= 8'h00;
			divCnt_q <= 8'h00;
			sckLvl_q <= 1'b0;
		end
		else
		begin
			case (ms_q)
				MS_IDLE:
				begin
					if (mLoad)
					begin
						csActive_q <= 1'b1;
						csCur_q <= targetIdx;
						curLast_q <= tdrLast_q;
						divCnt_q <= 8'h00;
						sckLvl_q <= tgtCfg.clockPolarity;
						ms_q <= MS_SHIFT;
					end
					else if (mSwitch)
					begin
						csActive_q <= 1'b0;
						gapCnt_q <= 8'h00;
						ms_q <= MS_GAP;
					end
				end
				MS_SHIFT:
				begin
					divCnt_q <= mTick ? 8'h00 : divCnt_q + 8'h01;
					if (mTick)
						sckLvl_q <= !sckLvl_q;
					if (mDone && !mKeep)
					begin
						csActive_q <= 1'b0;
						gapCnt_q <= 8'h00;
						ms_q <= MS_GAP;
					end
					else if (mDone)
						ms_q <= MS_IDLE;
				end
				MS_GAP:
				begin
					gapCnt_q <= gapCnt_q + 8'h01;
					if (gapCnt_q >= gapLen - 8'h01)
						ms_q <= MS_IDLE;
				end
				default:
					ms_q <= MS_IDLE;
			endcase
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	wire mDrive = isMaster && enabled_q;
	assign serialClockOut = sckLvl_q;
	assign serialClockOeN = !mDrive;
	assign mosiOut = outBit_q;
	assign mosiOeN = !mDrive;
	assign misoOut = outBit_q;
	assign misoOeN = !sActive;
	assign selectOut = csActive_q ? ~(4'h1 << csCur_q) : 4'hF;
	assign selectOeN = !mDrive;
	assign receiveDataReg = rxData_q;
	assign status = '{enabled: enabled_q, underrunFlag: underrun_q, overrunFlag: overrun_q,
		modeFaultFlag: modeFault_q, rxRegFullFlag: rxFull_q, txRegEmptyFlag: !txFull_q};
	assign wpStatus = '{protectViolationFlag: wpViol_q, violationSource: wpSrc_q};

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	fault_sets_flag_a: assert property (faultEv |=> modeFault_q && !enabled_q)
		else $error("mode fault did not set flag and disable");
	fault_stays_off_a: assert property (!enabled_q && !enableCommand |=> !enabled_q)
		else $error("controller re-enabled without enable command");
	wp_block_a: assert property (cfgBlocked |=> $stable(mode_q) && wpViol_q)
		else $error("protected write not blocked or not flagged");
	wp_clear_a: assert property (wpStatusRead && !cfgBlocked |=> !wpViol_q)
		else $error("violation flag not cleared by status read");
	overrun_set_a: assert property (wordDone && rxFull_q && !rxRead |=>
		overrun_q && rxData_q == $past(rxWord))
		else $error("overrun not flagged or word not loaded");
	gap_min_a: assert property ($fell(csActive_q) |-> !csActive_q [*6])
		else $error("select reasserted before six clocks");
	hold_keep_a: assert property (mDone && mHold |=> csActive_q && ms_q == MS_IDLE)
		else $error("held select released");
	force_rel_a: assert property (mDone && mForce |=> !csActive_q ##1 !csActive_q)
		else $error("forced release missing");
	load_empty_a: assert property (mLoad && !txWrite |=> status.txRegEmptyFlag && csActive_q)
		else $error("empty flag not raised at load");
	slave_under_a: assert property (sDone && !txFull_q && hasTx_q |=>
		underrun_q && sh_q == $past(tdr_q))
		else $error("underrun resend missing");

endmodule

// >>> hw/scp_pkg.sv
// Constants and types shared by the serial port controller
package scp_pkg;

	// ---------------------------------------------
	// Register offsets and reset values
	// ---------------------------------------------
	localparam logic [7:0] MODE_REG_OFFSET = 8'h04;
	localparam logic [7:0] CSR_BASE_OFFSET = 8'h30;
	localparam logic [15:0] SHIFT_RESET = 16'h0000;
	localparam logic [4:0] BASE_WORD_LEN = 5'h08;

	// ---------------------------------------------
	// Timing
	// ---------------------------------------------
	localparam logic [7:0] MIN_GAP_CYCLES = 8'h06;

	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef struct packed {
		logic [7:0] interSelectDelay;
		logic [3:0] pcs;
		logic modeFaultDisable;
		logic variableSelect;
		logic master;
	} scp_mode_t;

	typedef struct packed {
		logic [7:0] divider;
		logic [3:0] extraBits;
		logic holdSelectAfterWord;
		logic forceReleaseAfterWord;
		logic clockPhaseInverted;
		logic clockPolarity;
	} scp_csr_t;

	typedef struct packed {
		logic enabled;
		logic underrunFlag;
		logic overrunFlag;
		logic modeFaultFlag;
		logic rxRegFullFlag;
		logic txRegEmptyFlag;
	} scp_status_t;

	typedef struct packed {
		logic protectViolationFlag;
		logic [7:0] violationSource;
	} scp_wp_status_t;

	typedef enum logic [2:0] {
		MS_IDLE = 3'b001,
		MS_GAP = 3'b010,
		MS_SHIFT = 3'b100
	} scp_mstate_t;

endpackage

// >>> verification/scp_far_model.sv
// Far-side model: SPI slave capturing MOSI, and an external SPI master driving the slave pins
`timescale 1ns/10ps
module scp_far_model
(
	// Wire levels seen on the link
	input wire logic sckWire,
	input wire logic mosiWire,
	input wire logic misoWire,
	input wire logic selLow,
	// Far-side drivers
	output logic sckDrv,
	output logic mosiDrv,
	output logic ssDrv,
	output logic misoDrv,
	// Captured traffic
	output logic [15:0] capWord
);
	initial
	begin
		sckDrv = 1'b0;
		mosiDrv = 1'b0;
		ssDrv = 1'b1;
		misoDrv = 1'b1;
		capWord = 16'h0000;
	end

	// ---------------------------------------------
	// Slave role: rising-edge capture while selected
	// ---------------------------------------------
	always @(posedge sckWire)
	begin
		if (selLow)
			capWord = {capWord[14:0], mosiWire};
		misoDrv = ~misoDrv;
	end

	// ---------------------------------------------
	// Master role: one 8-bit word, sample on rising
	// ---------------------------------------------
	task automatic send(input logic [7:0] tx, output logic [7:0] rx);
		ssDrv = 1'b0;
		#300;
		for (int i = 7; i >= 0; i--)
		begin
			mosiDrv = tx[i];
			#100 sckDrv = 1'b1;
			rx[i] = misoWire;
			#100 sckDrv = 1'b0;
		end
		#100 mosiDrv = ~mosiDrv;
		#200 ssDrv = 1'b1;
		#300;
	endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the serial port controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top
	import scp_pkg::*;
;
	localparam logic [9:0] EN = 10'h200, DIS = 10'h100, FIN = 10'h080, TXW = 10'h040, RXR = 10'h020;
	localparam logic [9:0] STR = 10'h010, WPR = 10'h008, MW = 10'h004, CW = 10'h002, WPW = 10'h001;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [9:0] strb = 10'h000;
	logic [15:0] txData = 16'h0000;
	logic [1:0] csrIndex = 2'h0;
	scp_mode_t modeData = '0;
	scp_csr_t csrData = '0;
	logic writeProtectOn = 1'b0;
	logic extSel = 1'b1;
	scp_status_t status;
	scp_wp_status_t wpStatus;
	logic [15:0] receiveDataReg, capWord;
	logic sckOut, sckOeN, mosiOut, mosiOeN, misoOut, misoOeN, selectOeN;
	logic [3:0] selectOut;
	logic sckDrv, mosiDrv, ssDrv, misoDrv;
	logic [2:0] tbl [4] = '{3'b001, 3'b010, 3'b111, 3'b101};
	logic [7:0] r1, r2, rx;
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;
	int n;
	wire sckW = sckOeN ? sckDrv : sckOut;
	wire mosiW = mosiOeN ? mosiDrv : mosiOut;
	wire misoW = misoOeN ? misoDrv : misoOut;
	wire ssW = (selectOeN | selectOut[0]) & ssDrv & extSel;
	wire selLow = !selectOeN && !selectOut[0];

	always #12.5 clock = ~clock;

	scp_core u_scp_core
	(
		.clock(clock), .sys_rst(sys_rst),
		.enableCommand(strb[9]), .disableCommand(strb[8]), .finalWordRelease(strb[7]), .txWrite(strb[6]),
		.txData(txData), .txPcs(4'hE), .rxRead(strb[5]), .statusRead(strb[4]), .wpStatusRead(strb[3]),
		.modeWrite(strb[2]), .modeData(modeData), .csrWrite(strb[1]), .csrIndex(csrIndex), .csrData(csrData),
		.wpModeWrite(strb[0]), .writeProtectOn(writeProtectOn),
		.status(status), .receiveDataReg(receiveDataReg), .wpStatus(wpStatus),
		.serialClockIn(sckW), .serialClockOut(sckOut), .serialClockOeN(sckOeN),
		.mosiIn(mosiW), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
		.misoIn(misoW), .misoOut(misoOut), .misoOeN(misoOeN),
		.slaveSelectIn(ssW), .selectOut(selectOut), .selectOeN(selectOeN)
	);

	scp_far_model u_scp_far_model
	(
		.sckWire(sckW), .mosiWire(mosiW), .misoWire(misoW), .selLow(selLow),
		.sckDrv(sckDrv), .mosiDrv(mosiDrv), .ssDrv(ssDrv), .misoDrv(misoDrv), .capWord(capWord)
	);

	// ---------------------------------------------
	// Drivers
	// ---------------------------------------------
	task automatic cmd(input logic [9:0] m, input logic [7:0] d);
		@(posedge clock);
		strb <= m;
		txData <= {8'h00, d};
		@(posedge clock);
		strb <= 10'h000;
		@(negedge clock);
	endtask

	task automatic csr(input logic [1:0] i, input logic h, input logic f, input logic p);
		@(posedge clock);
		csrIndex <= i;
		csrData <= '{8'h04, 4'h0, h, f, 1'b1, p};
		cmd(CW, 8'h00);
	endtask

	task automatic mode(input logic mst, input logic mfd);
		@(posedge clock);
		modeData <= '{8'h03, 4'hE, mfd, 1'b0, mst};
		cmd(MW, 8'h00);
	endtask

	task automatic runLen(input logic lvl, input int lim, output int k);
		k = 0;
		while (selectOut[0] === lvl && k < lim)
		begin
			@(negedge clock);
			k++;
		end
	endtask

	// Two words (three with hold, the last one final) reloaded promptly under one select setting
	task automatic burst(input logic h, input logic f, input logic lng, input logic [7:0] a, input logic [7:0] b);
		logic [15:0] e;
		e = h ? {b, 8'hC3} : {a, b};
		csr(2'h0, h, f, 1'b0);
		cmd(TXW, a);
		@(negedge clock);
		`CHK("txEmpty", 1'b1, status.txRegEmptyFlag)
		`CHK("selLow", 1'b0, selectOut[0])
		cmd(TXW, b);
		runLen(1'b0, 300, n);
		`CHK("heldRun", lng, n > 80)
		if (f && !h)
		begin
			runLen(1'b1, 50, n);
			`CHK("gapLen", 1'b1, n >= 6)
			runLen(1'b0, 300, n);
		end
		if (h)
		begin
			cmd(FIN | TXW, 8'hC3);
			runLen(1'b0, 300, n);
		end
		`CHK("released", 1'b1, selectOut[0])
		`CHK("mosiWords", e, capWord)
		runLen(1'b1, 10, n);
	endtask

	task automatic end_sim;
		if (n_mismatch == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			end_sim;
		end
	end

	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial
	begin
		void'($urandom(32'h7c137952));
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(negedge clock);
		`CHK("rstStatus", 6'h01, status)
		`CHK("rstSelect", 4'hF, selectOut)
		@(posedge clock);
		writeProtectOn <= 1'b1;
		cmd(WPW, 8'h00);
		mode(1'b1, 1'b0);
		`CHK("wpMode", 9'h104, wpStatus)
		cmd(EN, 8'h00);
		`CHK("modeKept", 1'b1, selectOeN)
		cmd(WPR, 8'h00);
		`CHK("wpClear", 1'b0, wpStatus.protectViolationFlag)
		csr(2'h2, 1'b0, 1'b0, 1'b0);
		`CHK("wpCsr", 9'h138, wpStatus)
		cmd(WPR, 8'h00);
		@(posedge clock);
		writeProtectOn <= 1'b0;
		cmd(WPW, 8'h00);
		mode(1'b1, 1'b0);
		for (int i = 0; i < 4; i++)
			burst(tbl[i][2], tbl[i][1], tbl[i][0], 8'($urandom), 8'($urandom));
		mode(1'b1, 1'b1);
		@(posedge clock);
		extSel <= 1'b0;
		repeat (10) @(negedge clock);
		`CHK("faultMasked", 2'b10, {status.enabled, status.modeFaultFlag})
		mode(1'b1, 1'b0);
		repeat (20) @(negedge clock);
		`CHK("faultSeen", 2'b01, {status.enabled, status.modeFaultFlag})
		@(posedge clock);
		extSel <= 1'b1;
		repeat (20) @(negedge clock);
		`CHK("faultSticky", 2'b01, {status.enabled, status.modeFaultFlag})
		cmd(STR, 8'h00);
		`CHK("faultRead", 1'b0, status.modeFaultFlag)
		cmd(EN, 8'h00);
		`CHK("reEnabled", 1'b1, status.enabled)
		// Fresh reset so the slave shifter starts from zeros
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(negedge clock);
		`CHK("rstStatus2", 6'h01, status)
		`CHK("rstSelect2", 4'hF, selectOut)
		cmd(EN, 8'h00);
		mode(1'b0, 1'b0);
		csr(2'h1, 1'b0, 1'b0, 1'b1);
		csr(2'h0, 1'b0, 1'b0, 1'b0);
		r1 = 8'($urandom);
		r2 = 8'($urandom);
		u_scp_far_model.send(r1, rx);
		`CHK("misoZero", 8'h00, rx)
		`CHK("rxWord", {8'h00, r1}, receiveDataReg)
		`CHK("rxFull", 1'b1, status.rxRegFullFlag)
		u_scp_far_model.send(r2, rx);
		`CHK("misoEcho", r1, rx)
		`CHK("overrun", 2'b11, {status.overrunFlag, receiveDataReg == {8'h00, r2}})
		cmd(STR | RXR, 8'h00);
		`CHK("ovrClear", 1'b0, status.overrunFlag)
		cmd(TXW, r1);
		`CHK("firstDirect", 1'b1, status.txRegEmptyFlag)
		u_scp_far_model.send(r2, rx);
		`CHK("misoFirst", r1, rx)
		cmd(TXW, r2);
		`CHK("pending", 1'b0, status.txRegEmptyFlag)
		u_scp_far_model.send(r1, rx);
		`CHK("misoNext", r2, rx)
		`CHK("loaded", 1'b1, status.txRegEmptyFlag)
		cmd(STR, 8'h00);
		`CHK("underClr", 1'b0, status.underrunFlag)
		u_scp_far_model.send(r1, rx);
		`CHK("misoResend", r2, rx)
		`CHK("underrun", 1'b1, status.underrunFlag)
		cmd(DIS, 8'h00);
		`CHK("disabled", 1'b0, status.enabled)
		end_sim;
	end
endmodule
